// file: design/etr_pkg.sv
`default_nettype none

package etr_pkg;

    // ****************************************************************
    // Bus map
    // ****************************************************************
    localparam logic [7:0] ETR_CTRL_OFS   = 8'h00;
    localparam logic [7:0] ETR_STATUS_OFS = 8'h04;
    localparam logic [7:0] ETR_INIT_F_OFS = 8'h08;
    localparam logic [7:0] ETR_INIT_G_OFS = 8'h0c;

    // ****************************************************************
    // Control register fields
    // ****************************************************************
    localparam int ETR_MODE_LSB    = 0;
    localparam int ETR_DEPTH_LSB   = 2;
    localparam int ETR_FALL_BIT    = 4;
    localparam int ETR_FFOPP_BIT   = 5;
    localparam int ETR_DSEL_BIT    = 6;
    localparam int ETR_FFX_SRC_LSB = 7;
    localparam int ETR_FFY_SRC_LSB = 9;
    localparam int ETR_HTAB_LSB    = 16;
    localparam logic [31:0] ETR_CTRL_RST = 32'h0000_0001;

    // Status register fields
    localparam int ETR_ST_WCLK_BIT  = 8;
    localparam int ETR_ST_STALL_BIT = 9;
    localparam int ETR_ST_CNT_LSB   = 16;

    // Contents after reset (configuration preload)
    localparam logic [15:0] ETR_INIT_F_RST = 16'h0000;
    localparam logic [15:0] ETR_INIT_G_RST = 16'h0000;

    // ****************************************************************
    // Modes, depths, flip-flop sources
    // ****************************************************************
    localparam logic [1:0] ETR_MODE_LEVEL = 2'h0;
    localparam logic [1:0] ETR_MODE_EDGE  = 2'h1;
    localparam logic [1:0] ETR_MODE_DUAL  = 2'h2;
    localparam logic [1:0] ETR_MODE_LOGIC = 2'h3;

    localparam logic [1:0] ETR_DEPTH_16X2 = 2'h0;
    localparam logic [1:0] ETR_DEPTH_16X1 = 2'h1;
    localparam logic [1:0] ETR_DEPTH_32X1 = 2'h2;

    localparam logic [1:0] ETR_SRC_F  = 2'h0;
    localparam logic [1:0] ETR_SRC_G  = 2'h1;
    localparam logic [1:0] ETR_SRC_H  = 2'h2;
    localparam logic [1:0] ETR_SRC_D0 = 2'h3;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int ETR_CLK_PERIOD_NS     = 5;
    localparam int ETR_POST_EDGE_MAX_NS  = 1_000_000;
    localparam int ETR_POST_EDGE_MAX_CYC =
        ETR_POST_EDGE_MAX_NS / ETR_CLK_PERIOD_NS;

endpackage : etr_pkg

`default_nettype wire

// file: design/etr_clb_ram.sv
// The register addresses and the AHB-Lite register port are this design's own decisions.
`default_nettype none

module etr_clb_ram
    import etr_pkg::*;
#(
    parameter int STALL_LIMIT = etr_pkg::ETR_POST_EDGE_MAX_CYC
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        wclk,
    input  wire logic        write_enable,
    input  wire logic [3:0]  addr,
    input  wire logic [3:0]  dp_read_addr,
    input  wire logic        lower_data_input,
    input  wire logic        upper_data_input,
    output logic             single_port_read_out,
    output logic             dual_port_read_out,
    output logic             h_out,
    output logic             ffx_q,
    output logic             ffy_q
);

    // ****************************************************************
    // Bus slave
    // ****************************************************************
    logic        dp_wr_r;
    logic [7:0]  dp_ofs_r;
    logic [31:0] ctrl_r;
    logic [31:0] hrdata_r;
    logic        stall_r;
    logic [7:0]  wr_cnt_r;
    logic [4:0]  last_addr_r;
    logic [15:0] mem_f_r;
    logic [15:0] mem_g_r;
    logic [2:0]  wclk_s_r;

    wire addr_ok = hsel && hready && htrans[1];
    wire wr_ctrl = dp_wr_r && (dp_ofs_r == ETR_CTRL_OFS);
    wire wr_stat = dp_wr_r && (dp_ofs_r == ETR_STATUS_OFS);
    wire wr_initf = dp_wr_r && (dp_ofs_r == ETR_INIT_F_OFS);
    wire wr_initg = dp_wr_r && (dp_ofs_r == ETR_INIT_G_OFS);

    wire [31:0] status_w = {8'h00, wr_cnt_r, 6'h00, stall_r,
                            wclk_s_r[1], 3'h0, last_addr_r};
    wire [7:0]  rd_ofs = {haddr[7:2], 2'b00};
    wire        in_map = (haddr[31:8] == 24'h00_0000);
    wire [31:0] rd_mux =
        !in_map                        ? 32'h0000_0000 :
        (rd_ofs == ETR_CTRL_OFS)       ? ctrl_r :
        (rd_ofs == ETR_STATUS_OFS)     ? status_w :
        (rd_ofs == ETR_INIT_F_OFS)     ? {16'h0000, mem_f_r} :
        (rd_ofs == ETR_INIT_G_OFS)     ? {16'h0000, mem_g_r} :
                                         32'h0000_0000;

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr_r  <= 1'b0;
            dp_ofs_r <= 8'h00;
            hrdata_r <= 32'h0000_0000;
        end else begin
            dp_wr_r  <= addr_ok && hwrite && in_map;
            dp_ofs_r <= rd_ofs;
            if (addr_ok && !hwrite) begin
                hrdata_r <= rd_mux;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r <= ETR_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_r <= hwdata;
        end
    end

    // ****************************************************************
    // Configuration decode
    // ****************************************************************
    wire [1:0] mode   = ctrl_r[ETR_MODE_LSB +: 2];
    wire [1:0] depth  = ctrl_r[ETR_DEPTH_LSB +: 2];
    wire       fall   = ctrl_r[ETR_FALL_BIT];
    wire       ff_opp = ctrl_r[ETR_FFOPP_BIT];
    wire       dsel   = ctrl_r[ETR_DSEL_BIT];
    wire [1:0] xsrc   = ctrl_r[ETR_FFX_SRC_LSB +: 2];
    wire [1:0] ysrc   = ctrl_r[ETR_FFY_SRC_LSB +: 2];
    wire [7:0] htab   = ctrl_r[ETR_HTAB_LSB +: 8];

    wire m_level = (mode == ETR_MODE_LEVEL);
    wire m_dual  = (mode == ETR_MODE_DUAL);
    wire m_logic = (mode == ETR_MODE_LOGIC);
    // Dual port always runs as 16x1, whatever depth says
    wire d_32 = !m_dual && (depth == ETR_DEPTH_32X1);
    wire d_1  = !m_dual && (depth == ETR_DEPTH_16X1);

    // ****************************************************************
    // Write clock sampling and edge detection
    // ****************************************************************
    // The clock pin is foreign to hclk: two stages, then a history stage
    // Address, data and enable are delayed two stages to stay aligned
    logic [3:0] p1_addr_r;
    logic [3:0] p2_addr_r;
    logic [1:0] p1_d_r;
    logic [1:0] p2_d_r;
    logic       p1_we_r;
    logic       p2_we_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wclk_s_r  <= 3'h0;
            p1_addr_r <= 4'h0;
            p2_addr_r <= 4'h0;
            p1_d_r    <= 2'h0;
            p2_d_r    <= 2'h0;
            p1_we_r   <= 1'b0;
            p2_we_r   <= 1'b0;
        end else begin
            wclk_s_r  <= {wclk_s_r[1:0], wclk};
            p1_addr_r <= addr;
            p2_addr_r <= p1_addr_r;
            p1_d_r    <= {upper_data_input, lower_data_input};
            p2_d_r    <= p1_d_r;
            p1_we_r   <= write_enable;
            p2_we_r   <= p1_we_r;
        end
    end

    wire rise = wclk_s_r[1] && !wclk_s_r[2];
    wire fell = !wclk_s_r[1] && wclk_s_r[2];
    wire ram_edge = fall ? fell : rise;
    wire ff_edge = (fall ^ ff_opp) ? fell : rise;

    // ****************************************************************
    // Capture and internal write pulse
    // ****************************************************************
    logic [3:0] cap_addr_r;
    logic [1:0] cap_d_r;
    logic       cap_we_r;
    logic       wpulse_r;

    // Level mode writes each cycle the enable is high; logic mode never
    wire cap_en = !m_logic && (m_level || ram_edge);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cap_addr_r <= 4'h0;
            cap_d_r    <= 2'h0;
            cap_we_r   <= 1'b0;
            wpulse_r   <= 1'b0;
        end else begin
            wpulse_r <= cap_en && p2_we_r;
            if (cap_en) begin
                cap_addr_r <= p2_addr_r;
                cap_d_r    <= p2_d_r;
                cap_we_r   <= p2_we_r;
            end
        end
    end

    wire wr_go = wpulse_r && cap_we_r;
    wire cap_a4 = cap_d_r[1];
    wire data_f = (d_1 && dsel) ? cap_d_r[1] : cap_d_r[0];
    wire data_g = (m_dual || d_32) ? data_f : cap_d_r[1];
    wire sel_f = d_32 ? !cap_a4 : 1'b1;
    wire sel_g = d_32 ? cap_a4 : (m_dual || !d_1);

    // ****************************************************************
    // Storage, two flip-flops per entry (one in F, one in G)
    // ****************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_entry
            wire hit = wr_go && (cap_addr_r == 4'(gi));
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    mem_f_r[gi] <= ETR_INIT_F_RST[gi];
                    mem_g_r[gi] <= ETR_INIT_G_RST[gi];
                end else begin
                    // Configuration load overrides a user write
                    if (wr_initf) begin
                        mem_f_r[gi] <= hwdata[gi];
                    end else if (hit && sel_f) begin
                        mem_f_r[gi] <= data_f;
                    end
                    if (wr_initg) begin
                        mem_g_r[gi] <= hwdata[gi];
                    end else if (hit && sel_g) begin
                        mem_g_r[gi] <= data_g;
                    end
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Combinational read path
    // ****************************************************************
    // No clock in the read path: outputs follow addr immediately
    wire f_out = mem_f_r[addr];
    wire [3:0] g_addr = m_dual ? dp_read_addr : addr;
    wire g_out = mem_g_r[g_addr];

    assign single_port_read_out =
        (d_32 && upper_data_input) ? g_out : f_out;
    assign dual_port_read_out = g_out;
    assign h_out = htab[{upper_data_input, g_out, f_out}];

    // ****************************************************************
    // Block flip-flops on the shared clock pin
    // ****************************************************************
    wire [3:0] ff_src = {lower_data_input, h_out, g_out, f_out};
    logic ffx_r;
    logic ffy_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ffx_r <= 1'b0;
            ffy_r <= 1'b0;
        end else if (ff_edge) begin
            ffx_r <= ff_src[xsrc];
            ffy_r <= ff_src[ysrc];
        end
    end

    assign ffx_q = ffx_r;
    assign ffy_q = ffy_r;

    // ****************************************************************
    // Post-edge phase watch and status
    // ****************************************************************
    // A clock parked in its post-edge phase can damage the part, so in edge and dual mode a
    // sticky flag reports it; software clears it by writing a one
    logic [31:0] ph_cnt_r;
    wire post_phase = (wclk_s_r[1] == !fall);
    wire stall_hit = post_phase && (ph_cnt_r == 32'(STALL_LIMIT - 1));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_cnt_r <= 32'h0000_0000;
        end else if (!post_phase || m_logic || m_level) begin
            ph_cnt_r <= 32'h0000_0000;
        end else if (!stall_hit) begin
            ph_cnt_r <= ph_cnt_r + 32'h0000_0001;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stall_r <= 1'b0;
        end else if (stall_hit && !m_logic && !m_level) begin
            stall_r <= 1'b1;
        end else if (wr_stat && hwdata[ETR_ST_STALL_BIT]) begin
            stall_r <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_cnt_r    <= 8'h00;
            last_addr_r <= 5'h00;
        end else if (wr_go) begin
            wr_cnt_r    <= wr_cnt_r + 8'h01;
            last_addr_r <= {d_32 & cap_a4, cap_addr_r};
        end
    end

    wire unused_ok = &{1'b0, hsize, haddr[1:0]};

endmodule : etr_clb_ram

`default_nettype wire

// file: verif/etr_monitor.sv
`default_nettype none
module etr_monitor (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        wclk,
    input wire logic        write_enable,
    input wire logic [3:0]  addr,
    input wire logic [3:0]  dp_read_addr,
    input wire logic        lower_data_input,
    input wire logic        upper_data_input,
    input wire logic        single_port_read_out,
    input wire logic        dual_port_read_out,
    input wire logic        h_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import etr_pkg::*;
    // ************
    // Control shadow
    // ************
    logic            cw_r;
    logic [31:0]     ctrl_r;
    logic [3:0]      quiet_r;
    wire logic       bus_w  = hsel && htrans[1] && hwrite;
    wire logic       edge_m = ctrl_r[1:0] == ETR_MODE_EDGE;
    wire logic       fall   = ctrl_r[ETR_FALL_BIT];
    wire logic [1:0] dep    = ctrl_r[3:2];
    wire logic       up_sel = dep == ETR_DEPTH_16X1 && ctrl_r[ETR_DSEL_BIT];
    wire logic       din    = up_sel ? upper_data_input : lower_data_input;
    wire logic [2:0] hidx   = {upper_data_input, dual_port_read_out,
                               single_port_read_out};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cw_r    <= 1'b0;
            ctrl_r  <= ETR_CTRL_RST;
            quiet_r <= 4'h0;
        end else begin
            cw_r <= bus_w && haddr == 32'h0000_0000;
            if (cw_r) begin
                ctrl_r <= hwdata;
            end
            // Any write attempt restarts the idle count
            if (bus_w || write_enable) begin
                quiet_r <= 4'h0;
            end else if (quiet_r != 4'hf) begin
                quiet_r <= quiet_r + 4'h1;
            end
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    chk_reset_clear: assert property (
        $rose(hresetn) |-> !single_port_read_out && !dual_port_read_out
        && !h_out) else $error("read not clear after reset");
    chk_quiet_hold: assert property (
        quiet_r == 4'hf && $stable({addr, dp_read_addr, upper_data_input})
        |-> $stable({single_port_read_out, dual_port_read_out, h_out}))
        else $error("contents changed without enable");
    chk_edge_write: assert property (
        edge_m && !fall && dep != ETR_DEPTH_32X1 && $rose(wclk)
        && write_enable |-> ##6 (addr != $past(addr, 6)
        || single_port_read_out == $past(din, 6)))
        else $error("edge write not stored");
    chk_wide_write: assert property (
        edge_m && !fall && dep == ETR_DEPTH_32X1 && $rose(wclk)
        && write_enable |-> ##6 ({upper_data_input, addr}
        != $past({upper_data_input, addr}, 6)
        || single_port_read_out == $past(lower_data_input, 6)))
        else $error("deep write not stored");
    chk_fall_write: assert property (
        edge_m && fall && dep == ETR_DEPTH_16X2 && $fell(wclk)
        && write_enable |-> ##6 (addr != $past(addr, 6)
        || {dual_port_read_out, single_port_read_out}
        == $past({upper_data_input, lower_data_input}, 6)))
        else $error("falling edge write not stored");
    chk_dual_write: assert property (
        ctrl_r[1:0] == ETR_MODE_DUAL && !fall && $rose(wclk) && write_enable
        |-> ##6 (dp_read_addr != $past(addr, 6)
        || dual_port_read_out == $past(lower_data_input, 6)))
        else $error("dual port read wrong");
    chk_hfunc_table: assert property (
        edge_m && dep == ETR_DEPTH_16X2
        |-> h_out == ctrl_r[ETR_HTAB_LSB + hidx])
        else $error("third generator wrong");
    chk_level_write: assert property (
        (ctrl_r[1:0] == ETR_MODE_LEVEL && dep == ETR_DEPTH_16X2
        && write_enable && $stable({addr, lower_data_input}))[*8]
        |-> single_port_read_out == lower_data_input)
        else $error("level write not stored");
endmodule // etr_monitor

bind etr_clb_ram etr_monitor u_mon (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .wclk,
    .write_enable, .addr, .dp_read_addr, .lower_data_input,
    .upper_data_input, .single_port_read_out, .dual_port_read_out, .h_out
);
`default_nettype wire

// file: verif/etr_user_model.sv
`default_nettype none
module etr_user_model (
    input  wire logic  hclk,
    output logic       wclk,
    output logic       write_enable,
    output logic [3:0] addr,
    output logic [3:0] dp_read_addr,
    output logic       lower_data_input,
    output logic       upper_data_input
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        wclk = 1'b0;
        write_enable = 1'b0;
        addr = 4'h0;
        dp_read_addr = 4'h0;
        lower_data_input = 1'b0;
        upper_data_input = 1'b0;
    end

    // Inputs settle four cycles ahead of the active edge, held well after
    task automatic put(input logic [3:0] a, input logic u, input logic d,
                       input logic we, input int hold);
        addr             <= a;
        upper_data_input <= u;
        lower_data_input <= d;
        write_enable     <= we;
        repeat (4) @(posedge hclk);
        wclk <= ~wclk;
        // Only a long hold here breaks the post-edge limit
        repeat (hold) @(posedge hclk);
        wclk <= ~wclk;
        repeat (8) @(posedge hclk);
        write_enable <= 1'b0;
        @(posedge hclk);
    endtask

    task automatic look(input logic [3:0] a, input logic [3:0] dp,
                        input logic u);
        addr             <= a;
        dp_read_addr     <= dp;
        upper_data_input <= u;
        repeat (2) @(posedge hclk);
    endtask

    task automatic park(input logic v);
        wclk <= v;
        @(posedge hclk);
    endtask
endmodule // etr_user_model
`default_nettype wire

// file: verif/etr_clb_ram_tb.sv
`default_nettype none
module etr_clb_ram_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import etr_pkg::*;

    logic            hclk = 1'b0;
    logic            hresetn = 1'b0;
    logic            hsel = 1'b0;
    logic [31:0]     haddr = '0;
    logic [1:0]      htrans = '0;
    logic            hwrite = 1'b0;
    logic [31:0]     hwdata = '0;
    logic [31:0]     hrdata;
    logic            hreadyout;
    wire logic       wclk, write_enable, lower_data_input, upper_data_input;
    wire logic [3:0] addr, dp_read_addr;
    logic            single_port_read_out, dual_port_read_out, h_out;
    logic            ffx_q, ffy_q, hresp;
    logic [2:0]      hsize = 3'h2;
    logic [31:0]     rd;
    logic [15:0]     fm = 16'ha5c3;
    logic [15:0]     gm = 16'h0f0f;
    logic [7:0]      ht = 8'h96;
    int              err_total = 0;
    int              checked = 0;

    always #2.5 hclk = ~hclk;

    etr_clb_ram #(.STALL_LIMIT(20)) DUT (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .wclk,
        .write_enable, .addr, .dp_read_addr, .lower_data_input,
        .upper_data_input, .single_port_read_out, .dual_port_read_out,
        .h_out, .ffx_q, .ffy_q
    );
    etr_user_model PRT (
        .hclk, .wclk, .write_enable, .addr, .dp_read_addr,
        .lower_data_input, .upper_data_input
    );

    // **********
    // Bus and check tasks
    // **********
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        checked++;
        if (g !== e) begin
            $display("MISMATCH %s exp %h got %h", n, e, g);
            err_total++;
        end
    endtask

    task automatic xfer(input logic w, input logic [31:0] a,
                        input logic [31:0] wd);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk("hresp", 32'h0, 32'(hresp));
    endtask

    task automatic wr(input logic [7:0] o, input logic [31:0] d);
        xfer(1'b1, {24'h0, o}, d);
    endtask

    task automatic rchk(input logic [7:0] o, input logic [31:0] e);
        xfer(1'b0, {24'h0, o}, 32'h0);
        chk("register", e, rd);
    endtask

    task automatic mem_chk(input logic [3:0] a);
        PRT.look(a, a, 1'b0);
        chk("f_read", 32'(fm[a]), 32'(single_port_read_out));
        chk("g_read", 32'(gm[a]), 32'(dual_port_read_out));
    endtask

    task automatic wput(input logic [3:0] a, input logic u, input logic d);
        PRT.put(a, u, d, 1'b1, 4);
        fm[a] = d;
        gm[a] = u;
    endtask

    task automatic end_sim;
        $display("checked %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge hclk);
        err_total++;
        end_sim;
    end

    // **********
    // Scenarios
    // **********
    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rchk(ETR_CTRL_OFS, ETR_CTRL_RST);
        rchk(ETR_INIT_F_OFS, {16'h0, ETR_INIT_F_RST});
        xfer(1'b1, 32'h0000_0100, 32'hffff_ffff);
        xfer(1'b0, 32'h0000_0100, 32'h0);
        chk("unmapped", 32'h0, rd);
        wr(ETR_INIT_F_OFS, {16'h0, fm});
        wr(ETR_INIT_G_OFS, {16'h0, gm});
        rchk(ETR_INIT_G_OFS, {16'h0, gm});
        for (int i = 0; i < 16; i++) mem_chk(4'(i));
        wput(4'h3, 1'b0, 1'b1);
        wput(4'h0, 1'b1, 1'b0);
        wput(4'hf, 1'b1, 1'b1);
        PRT.put(4'h5, 1'b1, 1'b1, 1'b0, 4);
        for (int i = 0; i < 16; i++) mem_chk(4'(i));
        rchk(ETR_STATUS_OFS, 32'h0003_000f);
        wr(ETR_CTRL_OFS, 32'h0096_0001);
        for (int i = 0; i < 32; i++) begin
            PRT.look(4'(i), 4'(i), i[4]);
            chk("h_out", 32'(ht[{i[4], gm[i[3:0]], fm[i[3:0]]}]),
                32'(h_out));
        end
        wr(ETR_CTRL_OFS, 32'h0000_0011);
        PRT.park(1'b1);
        wput(4'h2, 1'b0, 1'b1);
        mem_chk(4'h2);
        PRT.park(1'b0);
        wr(ETR_CTRL_OFS, 32'h0000_0009);
        PRT.put(4'h5, 1'b1, 1'b1, 1'b1, 4);
        gm[5] = 1'b1;
        // Lower half write must leave the upper generator untouched
        PRT.put(4'hf, 1'b0, 1'b0, 1'b1, 4);
        fm[15] = 1'b0;
        for (int i = 0; i < 4; i++) begin
            PRT.look(i[1] ? 4'hf : 4'h5, i[1] ? 4'hf : 4'h5, i[0]);
            chk("deep", 32'(i[0] ? gm[i[1] ? 15 : 5] : fm[i[1] ? 15 : 5]),
                32'(single_port_read_out));
        end
        wr(ETR_CTRL_OFS, 32'h0000_0045);
        PRT.put(4'h9, 1'b1, 1'b0, 1'b1, 4);
        fm[9] = 1'b1;
        mem_chk(4'h9);
        wr(ETR_CTRL_OFS, 32'h0000_0002);
        PRT.look(4'h0, 4'h7, 1'b0);
        PRT.put(4'h7, 1'b0, 1'b1, 1'b1, 4);
        chk("dual", 32'h1, 32'(dual_port_read_out));
        fm[7] = 1'b1;
        gm[7] = 1'b1;
        wr(ETR_CTRL_OFS, 32'h0000_0000);
        mem_chk(4'h7);
        wput(4'h1, 1'b0, 1'b0);
        mem_chk(4'h1);
        wr(ETR_CTRL_OFS, 32'h0000_0003);
        PRT.put(4'ha, 1'b0, 1'b0, 1'b1, 4);
        wr(ETR_CTRL_OFS, 32'h0000_0001);
        mem_chk(4'ha);
        PRT.put(4'h0, 1'b0, 1'b0, 1'b0, 30);
        xfer(1'b0, {24'h0, ETR_STATUS_OFS}, 32'h0);
        chk("stall", 32'h1, 32'(rd[ETR_ST_STALL_BIT]));
        wr(ETR_STATUS_OFS, 32'h0000_0200);
        xfer(1'b0, {24'h0, ETR_STATUS_OFS}, 32'h0);
        chk("stall_clr", 32'h0, 32'(rd[ETR_ST_STALL_BIT]));
        // Block flip-flops: D0 and G sources on the RAM edge
        wr(ETR_CTRL_OFS, 32'h0000_0381);
        PRT.put(4'h0, 1'b0, 1'b0, 1'b0, 4);
        chk("ffx_d0", 32'h0, 32'(ffx_q));
        chk("ffy_g", 32'(gm[0]), 32'(ffy_q));
        // F and H sources on the opposite edge
        wr(ETR_CTRL_OFS, 32'h0000_0421);
        PRT.put(4'h3, 1'b0, 1'b0, 1'b0, 4);
        chk("ffx_f", 32'(fm[3]), 32'(ffx_q));
        chk("ffy_h", 32'h0, 32'(ffy_q));
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        fm = ETR_INIT_F_RST;
        gm = ETR_INIT_G_RST;
        mem_chk(4'h3);
        rchk(ETR_CTRL_OFS, ETR_CTRL_RST);
        end_sim;
    end
endmodule // etr_clb_ram_tb
`default_nettype wire
